// file: core/cies_pkg.sv
// Constants, encodings and carrier types for the instruction execution subset
package cies_pkg;

  // Widths and depths of the core datapath
  localparam int PC_W = 13;
  localparam int FA_W = 7;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_DEPTH = 128;

  // Opcode encodings (14-bit instruction word)
  localparam logic [2:0] OPC_CALL = 3'h4;
  localparam logic [13:0] OPC_WDCLR = 14'h0064;
  localparam logic [5:0] OPC_INV = 6'h09;
  localparam logic [5:0] OPC_CLR = 6'h01;
  localparam logic [5:0] OPC_DEC = 6'h03;
  localparam logic [5:0] OPC_DSZ = 6'h0b;

  // Field positions inside the instruction word and the upper PC latch
  localparam int DEST_BIT = 7;
  localparam int K_MSB = 10;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [SP_W-1:0] SP_RST = 3'h0;

  // Watchdog timing: prescaler period and counter terminal value
  localparam logic [7:0] WD_PRE_LAST = 8'hff;
  localparam logic [7:0] WD_CNT_LAST = 8'hff;
  localparam logic [7:0] WD_ZERO = 8'h00;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    CIES_EXEC = 3'b001,
    CIES_SKIP = 3'b010,
    CIES_JUMP = 3'b100
  } cies_state_t;

  // Status flags; expiry and sleep flags are active low
  typedef struct packed {
    logic expiry_n;
    logic sleep_n;
    logic zero;
  } cies_status_t;

  localparam cies_status_t STATUS_RST = 3'b110;

  // Decoded instruction carrier
  typedef struct packed {
    logic call;
    logic wdclr;
    logic inv;
    logic clear_file_op;
    logic clear_accumulator_op;
    logic dec;
    logic dsz;
    logic dest;
    logic [FA_W-1:0] faddr;
  } cies_dec_t;

endpackage : cies_pkg

// file: core/cies_core.sv
// Execution unit for call, watchdog clear, complement, clear and decrement ops
//
// What this block does
// - A watchdog clear zeroes the watchdog counter and its prescaler.
// - A watchdog clear sets the expiry and sleep flags to one and leaves zero flag alone.
// - A call pushes the current program counter plus one onto the stack top.
// - A call loads its 11-bit operand into program counter bits 10 to 0.
// - A call fills program counter bits 12 and 11 from latch bits 4 and 3.
// - A call takes two instruction cycles and changes no status flag.
// - Complement inverts the file register into accumulator or file and updates zero.
// - File clear writes zero to the file register and sets the zero flag.
// - Accumulator clear writes zero to the accumulator and sets the zero flag.
// - Decrement subtracts one, routes by the destination bit and updates zero.
// - Decrement-skip subtracts one, routes by destination and touches no flag.
// - A zero decrement-skip result replaces the next instruction with a no-op slot.
`timescale 1ns/1ps
module cies_core import cies_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_upper_pc_latch,
  input wire logic [FA_W-1:0] i_peek_addr,
  output logic [PC_W-1:0] o_pc,
  output logic [7:0] o_accum,
  output cies_status_t o_status,
  output logic [7:0] o_watchdog_counter,
  output logic o_watchdog_expired,
  output logic [SP_W-1:0] o_stack_ptr,
  output logic [PC_W-1:0] o_stack_top,
  output logic [7:0] o_peek_data,
  output logic o_no_operation_slot
);

  cies_state_t state;
  cies_status_t status;
  cies_dec_t dec;
  logic [PC_W-1:0] pc;
  logic [7:0] accum;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic [7:0] wd_pre;
  logic [7:0] wd_cnt;
  logic wd_fire;
  logic expired;
  logic exec;
  logic [7:0] fval;
  logic [7:0] res;
  logic wr_f;
  logic wr_w;
  logic upd_z;
  logic skip;
  logic [PC_W-1:0] ret_addr;
  logic [1:0] latch_hi;

  // Only instructions arriving in the execute state are acted on
  assign exec = i_instr_valid && (state == CIES_EXEC);
  assign fval = file_mem[dec.faddr];
  assign ret_addr = pc + 13'h0001;
  assign latch_hi = i_upper_pc_latch[LATCH_HI:LATCH_LO];

  // Decode; unknown words fall through as no-ops
  always_comb begin
    dec = '0;
    dec.faddr = i_instr[FA_W-1:0];
    dec.dest = i_instr[DEST_BIT];
    if (exec) begin
      if (i_instr[13:11] == OPC_CALL) begin
        dec.call = 1'b1;
      end else if (i_instr == OPC_WDCLR) begin
        dec.wdclr = 1'b1;
      end else begin
        case (i_instr[13:8])
          OPC_INV: dec.inv = 1'b1;
          OPC_CLR: begin
            dec.clear_file_op = i_instr[DEST_BIT];
            dec.clear_accumulator_op = ~i_instr[DEST_BIT];
          end
          OPC_DEC: dec.dec = 1'b1;
          OPC_DSZ: dec.dsz = 1'b1;
          default: dec.dsz = 1'b0;
        endcase
      end
    end
  end

  // Result path and its routing by the destination bit
  always_comb begin
    res = 8'h00;
    wr_f = 1'b0;
    wr_w = 1'b0;
    upd_z = 1'b0;
    skip = 1'b0;
    if (dec.inv) begin
      res = ~fval;
      wr_f = dec.dest;
      wr_w = ~dec.dest;
      upd_z = 1'b1;
    end else if (dec.clear_file_op) begin
      wr_f = 1'b1;
      upd_z = 1'b1;
    end else if (dec.clear_accumulator_op) begin
      wr_w = 1'b1;
      upd_z = 1'b1;
    end else if (dec.dec || dec.dsz) begin
      res = fval - 8'h01;
      wr_f = dec.dest;
      wr_w = ~dec.dest;
      upd_z = dec.dec; // Skip form leaves flags alone
      skip = dec.dsz && (res == 8'h00);
    end
  end

  // Sequencer: the slot after a call or a taken skip is swallowed
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= CIES_EXEC;
    end else if (i_instr_valid) begin
      unique case (state)
        CIES_EXEC: begin
          if (dec.call) begin
            state <= CIES_JUMP;
          end else if (skip) begin
            state <= CIES_SKIP;
          end else begin
            state <= CIES_EXEC;
          end
        end
        CIES_SKIP: state <= CIES_EXEC;
        CIES_JUMP: state <= CIES_EXEC;
        default: state <= CIES_EXEC;
      endcase
    end
  end

  // Program counter; a jump slot holds the target, a skip slot steps past
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc <= PC_RST;
    end else if (dec.call) begin
      pc <= {latch_hi, i_instr[K_MSB:0]};
    end else if (i_instr_valid && (state != CIES_JUMP)) begin
      pc <= ret_addr;
    end
  end

  // Return stack; the pointer wraps, so a ninth push overwrites the oldest
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sp <= SP_RST;
    end else if (dec.call) begin
      sp <= sp + 3'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (dec.call) begin
      stack[sp] <= ret_addr;
    end
  end

  // Accumulator
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      accum <= ACC_RST;
    end else if (wr_w) begin
      accum <= res;
    end
  end

  // File registers, one writer per entry
  for (genvar g = 0; g < FILE_DEPTH; g++) begin : g_file
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        file_mem[g] <= FILE_RST;
      end else if (wr_f && (dec.faddr == FA_W'(g))) begin
        file_mem[g] <= res;
      end
    end
  end

  // Watchdog prescaler and counter; terminal count marks an expiry
  assign wd_fire = (wd_pre == WD_PRE_LAST) && (wd_cnt == WD_CNT_LAST);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wd_pre <= WD_ZERO;
      wd_cnt <= WD_ZERO;
    end else if (dec.wdclr) begin
      wd_pre <= WD_ZERO;
      wd_cnt <= WD_ZERO;
    end else begin
      wd_pre <= wd_pre + 8'h01;
      if (wd_pre == WD_PRE_LAST) begin
        wd_cnt <= wd_cnt + 8'h01;
      end
    end
  end

  // Clearing restarts the count, so a same-cycle expiry is suppressed
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= wd_fire && !dec.wdclr;
    end
  end

  // Status flags
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status <= STATUS_RST;
    end else begin
      if (dec.wdclr) begin
        status.expiry_n <= 1'b1;
        status.sleep_n <= 1'b1;
      end else if (wd_fire) begin
        status.expiry_n <= 1'b0;
      end
      if (upd_z) begin
        status.zero <= (res == 8'h00);
      end
    end
  end

  // Outputs
  assign o_pc = pc;
  assign o_accum = accum;
  assign o_status = status;
  assign o_watchdog_counter = wd_cnt;
  assign o_watchdog_expired = expired;
  assign o_stack_ptr = sp;
  assign o_stack_top = stack[sp - 3'h1];
  assign o_peek_data = file_mem[i_peek_addr];
  assign o_no_operation_slot = i_instr_valid && (state != CIES_EXEC);

  // Checks on the execution semantics
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  property p_wd_clear;
    dec.wdclr |=> (wd_cnt == WD_ZERO) && (wd_pre == WD_ZERO);
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared");

  property p_wd_flags;
    dec.wdclr |=> status.expiry_n && status.sleep_n && $stable(status.zero);
  endproperty
  a_wd_flags: assert property (p_wd_flags) else $error("watchdog clear flags wrong");

  property p_call_push;
    dec.call |=> (stack[$past(sp)] == $past(ret_addr)) && (sp == $past(sp) + 3'h1);
  endproperty
  a_call_push: assert property (p_call_push) else $error("return address not pushed");

  property p_call_low;
    dec.call |=> pc[K_MSB:0] == $past(i_instr[K_MSB:0]);
  endproperty
  a_call_low: assert property (p_call_low) else $error("call target low bits wrong");

  property p_call_high;
    dec.call |=> pc[PC_W-1:K_MSB+1] == $past(latch_hi);
  endproperty
  a_call_high: assert property (p_call_high) else $error("call target high bits wrong");

  property p_call_two;
    dec.call |=> (state == CIES_JUMP) && $stable(status.zero) && $stable(status.sleep_n);
  endproperty
  a_call_two: assert property (p_call_two) else $error("call sequencing wrong");

  property p_acc_write;
    wr_w |=> (accum == $past(res)) && (accum == 8'h00 || !$past(dec.clear_accumulator_op));
  endproperty
  a_acc_write: assert property (p_acc_write) else $error("accumulator write wrong");

  property p_file_write;
    wr_f |=> file_mem[$past(dec.faddr)] == $past(res);
  endproperty
  a_file_write: assert property (p_file_write) else $error("file write wrong");

  property p_clear_file_op_zero;
    dec.clear_file_op |=> status.zero && (file_mem[$past(dec.faddr)] == 8'h00);
  endproperty
  a_clear_file_op_zero: assert property (p_clear_file_op_zero) else $error("file clear wrong");

  property p_inv_zero;
    dec.inv |=> status.zero == ($past(fval) == 8'hff);
  endproperty
  a_inv_zero: assert property (p_inv_zero) else $error("complement zero flag wrong");

  property p_dsz_flags;
    dec.dsz |=> $stable(status.zero);
  endproperty
  a_dsz_flags: assert property (p_dsz_flags) else $error("skip form changed zero flag");

  property p_skip_slot;
    dec.dsz && (fval == 8'h01) |=> (state == CIES_SKIP);
  endproperty
  a_skip_slot: assert property (p_skip_slot) else $error("zero result did not skip");

  property p_one_cycle;
    (dec.inv || dec.clear_file_op || dec.clear_accumulator_op || dec.dec || dec.wdclr) |=> state == CIES_EXEC;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("simple op took two cycles");

  c_call: cover property (dec.call ##1 o_no_operation_slot);
  c_skip: cover property (dec.dsz && skip ##1 o_no_operation_slot);
  c_noskip: cover property (dec.dsz && !skip);
  c_expire: cover property (o_watchdog_expired);

endmodule : cies_core

// file: tb/test_cpu_instr_exec_subset.sv
// Self-checking bench for the instruction execution subset with a reference model
`timescale 1ns/1ps
module test_cpu_instr_exec_subset;
  import cies_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_instr_valid = 1'b0;
  logic [13:0] i_instr = 14'h0000;
  logic [7:0] i_upper_pc_latch = 8'h00;
  logic [FA_W-1:0] i_peek_addr = 7'h00;
  logic [PC_W-1:0] o_pc;
  logic [7:0] o_accum;
  cies_status_t o_status;
  logic [7:0] o_watchdog_counter;
  logic o_watchdog_expired;
  logic [SP_W-1:0] o_stack_ptr;
  logic [PC_W-1:0] o_stack_top;
  logic [7:0] o_peek_data;
  logic o_no_operation_slot;
  int mismatches = 0;
  int compares = 0;
  // Model state; slot 1 follows a call, slot 2 follows a zero skip
  int pc = 0, acc = 0, zf = 0, exn = 1, sp = 0, pushes = 0, slot = 0, n = 0;
  int fm [128];
  int stk [8];

  cies_core uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_upper_pc_latch(i_upper_pc_latch), .i_peek_addr(i_peek_addr),
    .o_pc(o_pc), .o_accum(o_accum), .o_status(o_status),
    .o_watchdog_counter(o_watchdog_counter), .o_watchdog_expired(o_watchdog_expired),
    .o_stack_ptr(o_stack_ptr), .o_stack_top(o_stack_top), .o_peek_data(o_peek_data),
    .o_no_operation_slot(o_no_operation_slot));

  // Free-running core clock
  always #5 i_mclk = ~i_mclk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic check_all();
    check("pc", o_pc, pc[12:0]);
    check("accum", o_accum, acc[7:0]);
    check("status", o_status, {exn[0], 1'b1, zf[0]});
    check("stack_ptr", o_stack_ptr, sp[2:0]);
    check("peek", o_peek_data, fm[i_peek_addr]);
    if (pushes > 0) check("stack_top", o_stack_top, stk[(sp + 7) % 8]);
  endtask : check_all

  // Routes a result by the destination select bit
  task automatic put(input logic d, input int f, input int r);
    if (d) fm[f] = r;
    else acc = r;
  endtask : put

  function automatic logic [13:0] word(input int op, input logic d, input logic [6:0] f,
                                       input logic [10:0] k);
    case (op)
      0: return {OPC_CALL, k};
      1: return OPC_WDCLR;
      2: return {OPC_INV, d, f};
      3: return {OPC_CLR, 1'b1, f};
      4: return {OPC_CLR, 1'b0, 7'h00};
      5: return {OPC_DEC, d, f};
      default: return {OPC_DSZ, d, f};
    endcase
  endfunction : word

  // One instruction cycle: drive, predict, then compare after the edge
  task automatic step(input logic [13:0] w);
    int f, r, wd;
    f = w[6:0];
    wd = 0;
    i_instr = w;
    i_instr_valid = 1'b1;
    i_peek_addr = w[6:0];
    i_upper_pc_latch = $urandom;
    #1;
    check("slot", o_no_operation_slot, slot != 0);
    if (slot != 0) begin
      if (slot == 2) pc = (pc + 1) % 8192;
      slot = 0;
    end else begin
      pc = (pc + 1) % 8192;
      if (w[13:11] == OPC_CALL) begin
        stk[sp] = pc;
        sp = (sp + 1) % 8;
        pushes++;
        pc = {i_upper_pc_latch[LATCH_HI:LATCH_LO], w[K_MSB:0]};
        slot = 1;
      end else if (w == OPC_WDCLR) begin
        exn = 1;
        wd = 1;
      end else if (w[13:8] == OPC_INV) begin
        r = ~fm[f] & 255;
        put(w[7], f, r);
        zf = (r == 0);
      end else if (w[13:8] == OPC_CLR) begin
        put(w[7], f, 0);
        zf = 1;
      end else if (w[13:8] == OPC_DEC || w[13:8] == OPC_DSZ) begin
        r = (fm[f] + 255) % 256;
        put(w[7], f, r);
        if (w[13:8] == OPC_DEC) zf = (r == 0);
        else if (r == 0) slot = 2;
      end
    end
    @(posedge i_mclk);
    #1;
    check_all();
    if (wd) check("wd_counter", o_watchdog_counter, 0);
  endtask : step

  task automatic idle(input int cycles);
    i_instr_valid = 1'b0;
    repeat (cycles) @(posedge i_mclk);
    #1;
  endtask : idle

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Hang guard, well above the expiry wait plus the instruction mix
  initial begin
    #900000;
    mismatches++;
    wrap_up();
  end

  initial begin
    void'($urandom(19448));
    repeat (6) @(posedge i_mclk);
    #1;
    i_arst_n = 1'b1;
    check_all();
    // Prescaler runs well past zero first, so a missed prescaler clear shows
    idle(100);
    step(OPC_WDCLR);
    idle(249);
    check("wd_counter", o_watchdog_counter, 0);
    idle(21);
    check("wd_counter", o_watchdog_counter, 1);
    // Top address: ff, fe, 01, then a zero skip that discards a call
    step(word(3, 1, 127, 0));
    step(word(5, 1, 127, 0));
    step(word(5, 1, 127, 0));
    step(word(2, 1, 127, 0));
    step(word(6, 1, 127, 0));
    step(word(0, 0, 0, 11'h7ff));
    step(word(2, 0, 127, 0));
    step(word(4, 0, 0, 0));
    // Call into a discarded call, then a skip that falls through
    step(word(0, 0, 0, 11'h7ff));
    step(word(0, 0, 0, 11'h005));
    step(word(6, 0, 127, 0));
    // Random mix on a few addresses so zero results recur
    for (int i = 0; i < 600; i++) begin
      step(word($urandom % 7, $urandom % 2, $urandom % 4, $urandom % 2048));
    end
    // Let the watchdog run out, then recover with a watchdog clear
    i_instr_valid = 1'b0;
    while (o_watchdog_expired !== 1'b1 && n < 70000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    check("expired", o_watchdog_expired, 1);
    exn = 0;
    check_all();
    // A pending call slot would swallow the first clear, so the second one always executes
    step(OPC_WDCLR);
    step(OPC_WDCLR);
    wrap_up();
  end
endmodule : test_cpu_instr_exec_subset
